// [design/rsr_status_regs.sv]
// reader status register bank behind an avalon-mm slave
`include "rsr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module rsr_status_regs (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // avalon-mm slave, byte addressed
    input  wire logic [7:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // event sources
    input  wire rsr_pkg::rsr_crc_s   crc_ev,
    input  wire rsr_pkg::rsr_timer_s timer_in,
    input  wire rsr_pkg::rsr_irq_s   irq_in,
    input  wire rsr_pkg::rsr_link_s  link_in,
    input  wire logic              field_present_pin,
    // fifo activity
    input  wire logic              fifo_push,
    input  wire logic              fifo_pop,
    // card cipher, overheat and bus filter sources
    input  wire logic              auth_success,
    input  wire logic              rw_mode,
    input  wire logic              overheat_detect,
    input  wire logic [7:0]        temp_celsius,
    input  wire logic              bus_hs_protocol,
    // outputs to the rest of the reader
    output logic                   overheat_error,
    output logic                   bus_filter_fast,
    output logic                   card_cipher_active,
    output logic [2:0]             link_state,
    output logic [6:0]             fifo_fill_count,
    output logic                   fifo_high_warn,
    output logic                   fifo_low_warn
);

    rsr_pkg::rsr_state_s s_q;      // registered state
    rsr_pkg::rsr_state_s s_d;      // next state
    logic                req;      // a bus request is present
    logic                take;     // request completes this edge
    logic                wr_byte0; // write touches the data byte
    logic [5:0]          idx;      // register index from address
    logic                irq_any;  // enabled interrupt pending
    logic                timer_flag;
    logic [7:0]          s1_val;   // status_one readback
    logic [7:0]          s2_val;   // status_two readback
    logic [7:0]          rd_val;   // selected readback
    logic                fld;      // synchronised field presence
    logic                guard_ok; // guard elapsed and field ok
    logic [2:0]          link_code;

    // map sequencer position to its status code
    always_comb begin
        unique case (s_q.link)
            rsr_pkg::LINK_IDLE:        link_code = `RSR_LS_IDLE;
            rsr_pkg::LINK_WAIT_LAUNCH: link_code = `RSR_LS_WAIT_LAUNCH;
            rsr_pkg::LINK_TX_WAIT:     link_code = `RSR_LS_TX_WAIT;
            rsr_pkg::LINK_TRANSMIT:    link_code = `RSR_LS_TRANSMIT;
            rsr_pkg::LINK_RX_WAIT:     link_code = `RSR_LS_RX_WAIT;
            rsr_pkg::LINK_WAIT_DATA:   link_code = `RSR_LS_WAIT_DATA;
            rsr_pkg::LINK_RECEIVE:     link_code = `RSR_LS_RECEIVE;
            default:                   link_code = `RSR_LS_IDLE;
        endcase
    end

    // readback and decode helpers
    always_comb begin
        req      = avs_read | avs_write;
        // the master samples a low waitrequest while still requesting
        take     = req & ~s_q.waitreq;
        wr_byte0 = take & avs_write & avs_byteenable[0];
        idx      = avs_address[7:2];
        fld      = s_q.fld_s2;
        // enable masks of both enable groups apply
        irq_any  = |(irq_in.common_req & irq_in.common_interrupt_enable)
                 | |(irq_in.misc_req & irq_in.misc_interrupt_enable);
        // gated mode ignores the gate level itself
        if (timer_in.timer_gate_select != 2'h0) begin
            timer_flag = timer_in.enabled;
        end else begin
            timer_flag = timer_in.counting;
        end
        // reserved bits 7 and 2 stay zero
        s1_val = 8'h00;
        s1_val[`RSR_S1_CRC_ZERO]  = s_q.crc_zero;
        s1_val[`RSR_S1_CRC_DONE]  = s_q.crc_done;
        s1_val[`RSR_S1_IRQ]       = irq_any;
        s1_val[`RSR_S1_TIMER]     = timer_flag;
        s1_val[`RSR_S1_HIGH_WARN] = s_q.high_warn;
        s1_val[`RSR_S1_LOW_WARN]  = s_q.low_warn;
        // reserved bits 5 and 4 stay zero
        s2_val = 8'h00;
        s2_val[`RSR_S2_HEAT_CLEAR] = s_q.heat_clear;
        s2_val[`RSR_S2_FAST_FORCE] = s_q.fast_force;
        s2_val[`RSR_S2_CIPHER]     = s_q.cipher;
        s2_val[2:0]                = link_code;
        // unmapped addresses read as zero
        unique case (idx)
            `RSR_IDX_STATUS_ONE:  rd_val = s1_val;
            `RSR_IDX_STATUS_TWO:  rd_val = s2_val;
            `RSR_IDX_FILL_COUNT:  rd_val = {1'b0, s_q.fill};   // flush reads 0
            `RSR_IDX_WARN_THRESH: rd_val = {2'h0, s_q.thresh};
            default:              rd_val = 8'h00;
        endcase
    end

    // guard time and field check shared by both wait states
    always_comb begin
        // without wait_for_field the field is not awaited
        guard_ok = (s_q.guard == 8'h00)
                 & (fld | ~link_in.wait_for_field);
    end

    // next state of the whole bank
    always_comb begin
        s_d = s_q;

        // bus handshake: one wait cycle, then the answer for one edge
        if (req & s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            s_d.rdata   = {24'h000000, rd_val};
        end else begin
            s_d.waitreq = 1'b1;
        end
        if (!(avs_read & s_q.waitreq)) begin
            s_d.rdata = 32'h00000000;
        end

        // field pin synchroniser
        s_d.fld_s1 = field_present_pin;
        s_d.fld_s2 = s_q.fld_s1;

        // crc flags: zero flag drops while computing; a finish
        // in the same cycle as a start wins
        // no gating on radio traffic: the flag is left undefined
        // there and software is pointed at crc_fail_error
        if (crc_ev.start) begin
            s_d.crc_zero = 1'b0;
            s_d.crc_done = 1'b0;
        end
        if (crc_ev.finish) begin
            s_d.crc_zero = crc_ev.result_zero;
            if (crc_ev.by_command) begin
                s_d.crc_done = 1'b1;
            end
        end

        // fill count, saturating at the buffer bounds
        if (fifo_push & ~fifo_pop) begin
            if ({1'b0, s_q.fill} < `RSR_FIFO_DEPTH) begin
                s_d.fill = s_q.fill + 7'h01;
            end
        end else if (fifo_pop & ~fifo_push) begin
            if (s_q.fill != 7'h00) begin
                s_d.fill = s_q.fill - 7'h01;
            end
        end

        // software writes; status_one takes none of them
        if (wr_byte0) begin
            unique case (idx)
                `RSR_IDX_STATUS_TWO: begin
                    s_d.heat_clear = avs_writedata[`RSR_S2_HEAT_CLEAR];
                    s_d.fast_force = avs_writedata[`RSR_S2_FAST_FORCE];
                    // clear is honoured only once the die has cooled
                    if (avs_writedata[`RSR_S2_HEAT_CLEAR] &&
                        temp_celsius < `RSR_HEAT_LIMIT_C) begin
                        s_d.heat_err = 1'b0;
                    end
                    // software may only clear the cipher flag
                    if (!avs_writedata[`RSR_S2_CIPHER]) begin
                        s_d.cipher = 1'b0;
                    end
                end
                `RSR_IDX_FILL_COUNT: begin
                    // flush empties the count; a push in the
                    // same cycle is dropped with the flushed data
                    if (avs_writedata[`RSR_FC_FLUSH]) begin
                        s_d.fill = 7'h00;
                    end
                end
                `RSR_IDX_WARN_THRESH: begin
                    s_d.thresh = avs_writedata[5:0];
                end
                default: begin
                    // read-only or unmapped: ignored
                    s_d.thresh = s_q.thresh;
                end
            endcase
        end

        // hardware sets win over software clears
        if (overheat_detect) begin
            s_d.heat_err = 1'b1;
        end
        if (auth_success & rw_mode) begin
            s_d.cipher = 1'b1;
        end

        // watermarks follow the next fill count so they stay in step
        s_d.high_warn = (`RSR_FIFO_DEPTH - {1'b0, s_d.fill})
                      <= {2'h0, s_d.thresh};
        s_d.low_warn  = {1'b0, s_d.fill} <= {1'b0, s_d.thresh};

        // input filter: forced fast or following the protocol
        s_d.filter_fast = s_d.fast_force | bus_hs_protocol;

        // transmit/receive sequencer
        if (s_q.guard != 8'h00) begin
            s_d.guard = s_q.guard - 8'h01;
        end
        unique case (s_q.link)
            rsr_pkg::LINK_IDLE: begin
                if (link_in.arm) begin
                    s_d.link = rsr_pkg::LINK_WAIT_LAUNCH;
                end
            end
            rsr_pkg::LINK_WAIT_LAUNCH: begin
                if (link_in.launch_transmit) begin
                    s_d.link  = rsr_pkg::LINK_TX_WAIT;
                    s_d.guard = link_in.tx_guard_time;
                end
            end
            rsr_pkg::LINK_TX_WAIT: begin
                if (guard_ok) begin
                    s_d.link = rsr_pkg::LINK_TRANSMIT;
                end
            end
            rsr_pkg::LINK_TRANSMIT: begin
                if (link_in.tx_end) begin
                    s_d.link  = rsr_pkg::LINK_RX_WAIT;
                    s_d.guard = link_in.rx_guard_time;
                end
            end
            rsr_pkg::LINK_RX_WAIT: begin
                if (guard_ok) begin
                    s_d.link = rsr_pkg::LINK_WAIT_DATA;
                end
            end
            rsr_pkg::LINK_WAIT_DATA: begin
                if (link_in.rx_start) begin
                    s_d.link = rsr_pkg::LINK_RECEIVE;
                end
            end
            rsr_pkg::LINK_RECEIVE: begin
                // a still-armed command goes round again
                if (link_in.rx_end) begin
                    s_d.link = link_in.arm ? rsr_pkg::LINK_WAIT_LAUNCH
                                           : rsr_pkg::LINK_IDLE;
                end
            end
            default: begin
                s_d.link = rsr_pkg::LINK_IDLE;
            end
        endcase
        // a stopped command always returns to idle
        if (link_in.abort) begin
            s_d.link  = rsr_pkg::LINK_IDLE;
            s_d.guard = 8'h00;
        end
    end

    // state register; reset gives 21h and 00h readbacks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q             <= '0;
            s_q.waitreq     <= 1'b1;
            // each flag keeps bit 0 of its shifted reset byte
            s_q.crc_zero    <= 1'(`RSR_RST_STATUS_ONE >> `RSR_S1_CRC_ZERO);
            s_q.crc_done    <= 1'(`RSR_RST_STATUS_ONE >> `RSR_S1_CRC_DONE);
            s_q.low_warn    <= 1'(`RSR_RST_STATUS_ONE >> `RSR_S1_LOW_WARN);
            s_q.high_warn   <= 1'(`RSR_RST_STATUS_ONE >> `RSR_S1_HIGH_WARN);
            s_q.heat_clear  <= 1'(`RSR_RST_STATUS_TWO >> `RSR_S2_HEAT_CLEAR);
            s_q.thresh      <= `RSR_RST_WARN_THRESH;
            s_q.link        <= rsr_pkg::LINK_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    always_comb begin
        avs_readdata       = s_q.rdata;
        avs_waitrequest    = s_q.waitreq;
        overheat_error     = s_q.heat_err;
        bus_filter_fast    = s_q.filter_fast;
        card_cipher_active = s_q.cipher;
        link_state         = s_q.link;
        fifo_fill_count    = s_q.fill;
        fifo_high_warn     = s_q.high_warn;
        fifo_low_warn      = s_q.low_warn;
    end

endmodule // rsr_status_regs

`default_nettype wire

// [design/rsr_defines.svh]
// constants of the reader status register bank
`ifndef RSR_DEFINES_SVH
`define RSR_DEFINES_SVH

// register indices, byte address is four times the index
`define RSR_IDX_STATUS_ONE   6'h07
`define RSR_IDX_STATUS_TWO   6'h08
`define RSR_IDX_FILL_COUNT   6'h0a
`define RSR_IDX_WARN_THRESH  6'h0b

// reset values
`define RSR_RST_STATUS_ONE   8'h21
`define RSR_RST_STATUS_TWO   8'h00
`define RSR_RST_WARN_THRESH  6'h08

// status_one bit positions
`define RSR_S1_CRC_ZERO      6
`define RSR_S1_CRC_DONE      5
`define RSR_S1_IRQ           4
`define RSR_S1_TIMER         3
`define RSR_S1_HIGH_WARN     1
`define RSR_S1_LOW_WARN      0

// status_two bit positions
`define RSR_S2_HEAT_CLEAR    7
`define RSR_S2_FAST_FORCE    6
`define RSR_S2_CIPHER        3

// fill count register: flush strobe position
`define RSR_FC_FLUSH         7

// link state codes
`define RSR_LS_IDLE          3'h0
`define RSR_LS_WAIT_LAUNCH   3'h1
`define RSR_LS_TX_WAIT       3'h2
`define RSR_LS_TRANSMIT      3'h3
`define RSR_LS_RX_WAIT       3'h4
`define RSR_LS_WAIT_DATA     3'h5
`define RSR_LS_RECEIVE       3'h6

// fifo depth and overheat clear limit in degrees
`define RSR_FIFO_DEPTH       8'h40
`define RSR_HEAT_LIMIT_C     8'h7d

`endif

// [design/rsr_pkg.sv]
// types of the reader status register bank
package rsr_pkg;

    // position of the transmit/receive sequencer
    typedef enum logic [2:0] {
        LINK_IDLE, LINK_WAIT_LAUNCH, LINK_TX_WAIT, LINK_TRANSMIT,
        LINK_RX_WAIT, LINK_WAIT_DATA, LINK_RECEIVE
    } rsr_link_e;

    // crc coprocessor events
    typedef struct packed {
        logic start;        // calculation begins
        logic finish;       // calculation ends
        logic by_command;   // run was launched by crc_compute_command
        logic result_zero;  // result register equals zero
    } rsr_crc_s;

    // timer unit view
    typedef struct packed {
        logic       counting;          // decrements on next timer clock
        logic [1:0] timer_gate_select; // nonzero selects gated mode
        logic       enabled;           // timer started, gate level ignored
    } rsr_timer_s;

    // interrupt sources and enables
    typedef struct packed {
        logic [7:0] common_req;
        logic [7:0] common_interrupt_enable;
        logic [7:0] misc_req;
        logic [7:0] misc_interrupt_enable;
    } rsr_irq_s;

    // sequencer events and settings
    typedef struct packed {
        logic       arm;            // transceive command active
        logic       launch_transmit;
        logic       tx_end;         // last bit sent
        logic       rx_start;       // first bit seen
        logic       rx_end;         // frame received
        logic       abort;          // command stopped
        logic       wait_for_field;
        logic [7:0] tx_guard_time;
        logic [7:0] rx_guard_time;
    } rsr_link_s;

    // whole state of the bank
    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
        logic        crc_zero;
        logic        crc_done;
        logic [6:0]  fill;
        logic [5:0]  thresh;
        logic        high_warn;
        logic        low_warn;
        logic        heat_clear;
        logic        fast_force;
        logic        filter_fast;
        logic        heat_err;
        logic        cipher;
        rsr_link_e   link;
        logic [7:0]  guard;
        logic        fld_s1;
        logic        fld_s2;
    } rsr_state_s;

endpackage : rsr_pkg

// [testbench/rsr_status_regs_chk.sv]
// assertion checker for the reader status register bank
`timescale 1ns/1ps
`default_nettype none

module rsr_status_regs_chk (
    // clock and reset
    input wire logic               clk,
    input wire logic               resetn,
    // register bus, only the write strobe matters here
    input wire logic               avs_write,
    // fifo activity and warnings
    input wire logic               fifo_push,
    input wire logic               fifo_pop,
    input wire logic [6:0]         fifo_fill_count,
    input wire logic               fifo_high_warn,
    input wire logic               fifo_low_warn,
    // cipher and bus filter
    input wire logic               auth_success,
    input wire logic               rw_mode,
    input wire logic               card_cipher_active,
    input wire logic               bus_hs_protocol,
    input wire logic               bus_filter_fast,
    // sequencer
    input wire rsr_pkg::rsr_link_s link_in,
    input wire logic [2:0]         link_state
);
    // one domain: clock and reset given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // an empty fifo is always at or below any threshold
    property p_low_empty; fifo_fill_count == 7'h00 |-> fifo_low_warn; endproperty
    a_low_empty: assert property (p_low_empty) else $error("low warning missing on empty fifo");
    // full fifo: no free space, high warning
    property p_high_full; fifo_fill_count == 7'h40 |-> fifo_high_warn; endproperty
    a_high_full: assert property (p_high_full) else $error("high warning missing on full fifo");
    // writes excluded: a flush may land the same cycle
    property p_push;
        fifo_push && !fifo_pop && !avs_write && fifo_fill_count < 7'h40
        |=> fifo_fill_count == $past(fifo_fill_count) + 7'h01;
    endproperty
    a_push: assert property (p_push) else $error("fill count did not rise on push");
    property p_pop;
        fifo_pop && !fifo_push && !avs_write && fifo_fill_count != 7'h00
        |=> fifo_fill_count == $past(fifo_fill_count) - 7'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("fill count did not fall on pop");
    // set only by authentication in read/write mode
    property p_cipher_set; auth_success && rw_mode |=> card_cipher_active; endproperty
    a_cipher_set: assert property (p_cipher_set) else $error("cipher flag not set");
    property p_cipher_rise;
        $rose(card_cipher_active) |-> $past(auth_success) && $past(rw_mode);
    endproperty
    a_cipher_rise: assert property (p_cipher_rise) else $error("cipher flag rose alone");
    property p_filter; bus_hs_protocol |=> bus_filter_fast; endproperty
    a_filter: assert property (p_filter) else $error("fast filter not following protocol");
    // code 111 is never used by the sequencer
    property p_code_range; link_state != 3'h7; endproperty
    a_code_range: assert property (p_code_range) else $error("undefined link state code");
    property p_abort; link_in.abort |=> link_state == 3'h0; endproperty
    a_abort: assert property (p_abort) else $error("abort did not return to idle");
    // transmitting is reached only through the transmit wait
    property p_tx_entry;
        link_state == 3'h3 && $past(link_state) != 3'h3 |-> $past(link_state) == 3'h2;
    endproperty
    a_tx_entry: assert property (p_tx_entry) else $error("transmit entered without wait");
    property p_data_entry;
        link_state == 3'h5 && $past(link_state) != 3'h5 |-> $past(link_state) == 3'h4;
    endproperty
    a_data_entry: assert property (p_data_entry) else $error("wait for data skipped rx wait");

    // main scenarios reached
    c_full: cover property (fifo_fill_count == 7'h40);
    c_transmit: cover property (link_state == 3'h3);
    c_cipher: cover property ($rose(card_cipher_active));
endmodule // rsr_status_regs_chk

bind rsr_status_regs rsr_status_regs_chk u_chk (
    .clk(clk), .resetn(resetn), .avs_write(avs_write),
    .fifo_push(fifo_push), .fifo_pop(fifo_pop), .fifo_fill_count(fifo_fill_count),
    .fifo_high_warn(fifo_high_warn), .fifo_low_warn(fifo_low_warn),
    .auth_success(auth_success), .rw_mode(rw_mode), .card_cipher_active(card_cipher_active),
    .bus_hs_protocol(bus_hs_protocol), .bus_filter_fast(bus_filter_fast),
    .link_in(link_in), .link_state(link_state)
);

`default_nettype wire

// [testbench/rsr_status_regs_bench.sv]
// self-checking bench for the reader status register bank
`timescale 1ns/1ps
`default_nettype none

module rsr_status_regs_bench;
    // design inputs
    logic                clk = 1'b0;
    logic                resetn = 1'b0;
    logic [7:0]          avs_address = 8'h00;
    logic                avs_read = 1'b0;
    logic                avs_write = 1'b0;
    logic [31:0]         avs_writedata = 32'h0;
    logic [3:0]          avs_byteenable = 4'h0;
    rsr_pkg::rsr_crc_s   crc_ev = '0;
    rsr_pkg::rsr_timer_s timer_in = '0;
    rsr_pkg::rsr_irq_s   irq_in = '0;
    rsr_pkg::rsr_link_s  link_in = '0;
    logic                field_present_pin = 1'b0;
    logic                fifo_push = 1'b0;
    logic                fifo_pop = 1'b0;
    logic                auth_success = 1'b0;
    logic                rw_mode = 1'b0;
    logic                overheat_detect = 1'b0;
    logic [7:0]          temp_celsius = 8'h14;
    logic                bus_hs_protocol = 1'b0;
    // design outputs
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic                overheat_error;
    logic                bus_filter_fast;
    logic                card_cipher_active;
    logic [2:0]          link_state;
    logic [6:0]          fifo_fill_count;
    logic                fifo_high_warn;
    logic                fifo_low_warn;
    // bookkeeping
    int                  num_errors = 0;
    int                  n_compared = 0;
    int                  cyc = 0;
    int                  n;
    logic [31:0]         rdata;

    rsr_status_regs dut (
        .clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .crc_ev, .timer_in,
        .irq_in, .link_in, .field_present_pin, .fifo_push, .fifo_pop,
        .auth_success, .rw_mode, .overheat_detect, .temp_celsius, .bus_hs_protocol,
        .overheat_error, .bus_filter_fast, .card_cipher_active, .link_state,
        .fifo_fill_count, .fifo_high_warn, .fifo_low_warn
    );

    // 25 mhz clock
    always #20 clk = ~clk;

    // verdict, the only exit
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            finish_test();
        end
    end

    // one comparison, four-state exact
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // avalon access, held until waitrequest is low; only the hang guard ends it
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        do @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // idle edge: the next call never re-drives here
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00, 4'hf);
        chk("readdata", rdata, {24'h0, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d, 4'h1);
    endtask

    // fifo strobes held for n edges
    task automatic fifo(input logic pu, input logic po, input int cnt);
        fifo_push <= pu;
        fifo_pop <= po;
        repeat (cnt) @(posedge clk);
        fifo_push <= 1'b0;
        fifo_pop <= 1'b0;
        @(posedge clk);
    endtask
    // crc pulse: start finish by_command result_zero
    task automatic crc(input logic [3:0] v);
        crc_ev <= v;
        @(posedge clk);
        crc_ev <= '0;
        @(posedge clk);
    endtask
    // one-cycle pulse on a sequencer event bit
    task automatic lpulse(input int b);
        link_in[b] <= 1'b1;
        @(posedge clk);
        link_in[b] <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        // reset values, read-only and refused accesses
        rd(8'h1c, 8'h21);
        rd(8'h20, 8'h00);
        rd(8'h2c, 8'h08);
        rd(8'h3c, 8'h00);
        wr(8'h1c, 8'hff);
        rd(8'h1c, 8'h21);
        acc(1'b1, 8'h2c, 8'h3f, 4'h0);
        rd(8'h2c, 8'h08);
        $display("reset test done");
        // watermarks at threshold 4, boundaries 4/5 and 59/60
        wr(8'h2c, 8'h04);
        fifo(1'b1, 1'b0, 4);
        chk("fill count", 32'(fifo_fill_count), 32'h4);
        rd(8'h1c, 8'h21);
        fifo(1'b1, 1'b0, 1);
        rd(8'h1c, 8'h20);
        fifo(1'b1, 1'b0, 54);
        rd(8'h1c, 8'h20);
        fifo(1'b1, 1'b0, 1);
        rd(8'h1c, 8'h22);
        fifo(1'b1, 1'b0, 6);
        rd(8'h28, 8'h40);
        fifo(1'b1, 1'b1, 3);
        fifo(1'b0, 1'b1, 1);
        chk("fill count", 32'(fifo_fill_count), 32'h3f);
        wr(8'h28, 8'h80);
        chk("fill count", 32'(fifo_fill_count), 32'h0);
        $display("fifo test done");
        // crc busy, done by command, done without command
        crc(4'b1000);
        rd(8'h1c, 8'h01);
        crc(4'b0111);
        rd(8'h1c, 8'h61);
        crc(4'b1000);
        crc(4'b0100);
        rd(8'h1c, 8'h01);
        // interrupt summary with and without enables
        irq_in <= 32'h01000000;
        rd(8'h1c, 8'h01);
        irq_in <= 32'h01010000;
        rd(8'h1c, 8'h11);
        irq_in <= 32'h00000404;
        rd(8'h1c, 8'h11);
        irq_in <= '0;
        // timer: free running, gated enabled, gated not enabled
        timer_in <= 4'b1000;
        rd(8'h1c, 8'h09);
        timer_in <= 4'b0011;
        rd(8'h1c, 8'h09);
        timer_in <= 4'b1100;
        rd(8'h1c, 8'h01);
        timer_in <= '0;
        $display("status one test done");
        // fast filter force and protocol
        wr(8'h20, 8'h40);
        rd(8'h20, 8'h40);
        chk("filter fast", 32'(bus_filter_fast), 32'h1);
        wr(8'h20, 8'h00);
        rd(8'h20, 8'h00);
        chk("filter fast", 32'(bus_filter_fast), 32'h0);
        bus_hs_protocol <= 1'b1;
        repeat (2) @(posedge clk);
        chk("filter fast", 32'(bus_filter_fast), 32'h1);
        bus_hs_protocol <= 1'b0;
        // overheat clear refused at 125, taken below
        overheat_detect <= 1'b1;
        @(posedge clk);
        overheat_detect <= 1'b0;
        temp_celsius <= 8'd125;
        wr(8'h20, 8'h80);
        chk("overheat", 32'(overheat_error), 32'h1);
        temp_celsius <= 8'd124;
        wr(8'h20, 8'h80);
        chk("overheat", 32'(overheat_error), 32'h0);
        wr(8'h20, 8'h00);
        // cipher outside, inside read/write mode; clear
        auth_success <= 1'b1;
        @(posedge clk);
        auth_success <= 1'b0;
        rw_mode <= 1'b1;
        @(posedge clk);
        chk("cipher", 32'(card_cipher_active), 32'h0);
        auth_success <= 1'b1;
        @(posedge clk);
        auth_success <= 1'b0;
        @(posedge clk);
        rd(8'h20, 8'h08);
        wr(8'h20, 8'h08);
        chk("cipher", 32'(card_cipher_active), 32'h1);
        wr(8'h20, 8'h00);
        chk("cipher", 32'(card_cipher_active), 32'h0);
        $display("status two test done");
        // sequencer walk; bits 22 arm 21 launch 20 tx end 19 rx start 18 rx end 17 abort
        link_in.tx_guard_time <= 8'h03;
        link_in.rx_guard_time <= 8'h02;
        link_in.arm <= 1'b1;
        repeat (2) @(posedge clk);
        chk("link state", 32'(link_state), 32'h1);
        rd(8'h20, 8'h01);
        lpulse(21);
        n = 0;
        while (link_state === 3'h2 && n < 50) begin
            n++;
            @(posedge clk);
        end
        chk("tx wait cycles", 32'(n), 32'h4);
        chk("link state", 32'(link_state), 32'h3);
        link_in.wait_for_field <= 1'b1;
        lpulse(20);
        repeat (10) @(posedge clk);
        chk("link state", 32'(link_state), 32'h4);
        field_present_pin <= 1'b1;
        n = 0;
        while (link_state === 3'h4 && n < 20) begin
            n++;
            @(posedge clk);
        end
        chk("link state", 32'(link_state), 32'h5);
        lpulse(19);
        chk("link state", 32'(link_state), 32'h6);
        lpulse(18);
        chk("link state", 32'(link_state), 32'h1);
        lpulse(17);
        chk("link state", 32'(link_state), 32'h0);
        $display("link test done");
        finish_test();
    end
endmodule // rsr_status_regs_bench

`default_nettype wire
